// ==== rtl/mas_params.svh ====
// Purpose: constants of the mutual authentication and session key block
// Assumes: 250 MHz system clock, one domain
// Notes:   widths are fixed; widths of literals match the signals they meet
`ifndef MAS_PARAMS_SVH
`define MAS_PARAMS_SVH

// ====================================================================
// sizes
`define MAS_BLK_W        128
`define MAS_RSP_W        256
`define MAS_HALF_W       64
`define MAS_FAIL_W       3

// ====================================================================
// values
`define MAS_CBC_IV       128'h0
`define MAS_NONCE_CLEAR  128'h0
`define MAS_RSP_CLEAR    256'h0
`define MAS_FAIL_LIMIT   3'h5
`define MAS_FAIL_ZERO    3'h0
`define MAS_FAIL_ONE     3'h1
`define MAS_FAIL_MAX     3'h7
`define MAS_LFSR_SEED    128'h0123456789ABCDEF0F1E2D3C4B5A6978

// ====================================================================
// generator feedback taps, x^128 + x^126 + x^101 + x^99 + 1
`define MAS_TAP_A        127
`define MAS_TAP_B        125
`define MAS_TAP_C        100
`define MAS_TAP_D        98

`endif

// ==== rtl/mas_pkg.sv ====
// Purpose: types of the mutual authentication and session key block
// Assumes: included constants from mas_params.svh
// Notes:   state codes are one-hot
package mas_pkg;

	// ====================================================================
	// exchange sequencer states
	typedef enum logic [5:0] {
		S_IDLE     = 6'h01,
		S_ENC_A    = 6'h02,
		S_WAIT_RSP = 6'h04,
		S_DEC0     = 6'h08,
		S_DEC1     = 6'h10,
		S_ENC_B    = 6'h20
	} mas_state_e;

	typedef logic [127:0] mas_blk_t;

endpackage

// ==== rtl/mas_nonce_gen.sv ====
// Purpose: free-running 128-bit nonce source
// Assumes: entropy_in is a noisy bit from outside, synchronous to clk
// Notes:   without real entropy the sequence is predictable; feed entropy_in
`include "mas_params.svh"

module mas_nonce_gen import mas_pkg::*; (
	input  wire logic     clk,
	input  wire logic     reset_n,
	input  wire logic     entropy_in,
	output mas_blk_t      nonce
);

	// ====================================================================
	// shift register
	mas_blk_t lfsr_ff;
	wire      feedback;

	assign feedback = lfsr_ff[`MAS_TAP_A] ^ lfsr_ff[`MAS_TAP_B] ^ lfsr_ff[`MAS_TAP_C]
	                  ^ lfsr_ff[`MAS_TAP_D] ^ entropy_in;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_ff <= `MAS_LFSR_SEED;
		end else begin
			lfsr_ff <= {lfsr_ff[126:0], feedback};
		end
	end

	assign nonce = lfsr_ff;

endmodule

// ==== rtl/mas_auth_core.sv ====
// Purpose: reader end of the challenge-response exchange and session key forming
// Assumes: an outside block cipher engine runs single 128-bit blocks on request
// Notes:   cbc chaining and the zero initial vector are applied here around the engine
`include "mas_params.svh"

module mas_auth_core import mas_pkg::*; (
	input  wire logic     clk,
	input  wire logic     reset_n,
	input  wire logic     entropy_in,
	input  mas_blk_t      root_key,
	input  wire logic     auth_req,
	input  wire logic     rsp_valid,
	input  wire logic [255:0] rsp_data,
	output logic          ans_valid,
	output mas_blk_t      ans_data,
	output logic          ans_final,
	output logic          req_refused,
	output logic          auth_fail,
	output logic          locked_out,
	output logic          busy,
	output mas_blk_t      session_key,
	output logic          session_valid,
	input  wire logic     secure_wr_req,
	output logic          secure_wr_ok,
	output logic          cph_start,
	output logic          cph_decrypt,
	output mas_blk_t      cph_key,
	output mas_blk_t      cph_din,
	input  wire logic     cph_done,
	input  mas_blk_t      cph_dout
);

	// ====================================================================
	// storage
	mas_state_e                 state_ff;
	mas_state_e                 nxt_state;
	logic                       launched_ff;
	mas_blk_t                   reader_nonce_ff;
	mas_blk_t                   server_nonce_ff;
	logic [255:0]               rsp_ff;
	logic [`MAS_FAIL_W-1:0]     fail_cnt_ff;
	mas_blk_t                   session_key_ff;
	logic                       session_valid_ff;
	mas_blk_t                   ans_data_ff;
	logic                       ans_valid_ff;
	logic                       ans_final_ff;
	logic                       auth_fail_ff;
	logic                       req_refused_ff;
	mas_blk_t                   fresh_nonce;

	mas_nonce_gen u_nonce (
		.clk        (clk),
		.reset_n    (reset_n),
		.entropy_in (entropy_in),
		.nonce      (fresh_nonce)
	);

	// ====================================================================
	// decode
	wire st_idle  = (state_ff == S_IDLE);
	wire st_enc_a = (state_ff == S_ENC_A);
	wire st_wait  = (state_ff == S_WAIT_RSP);
	wire st_dec0  = (state_ff == S_DEC0);
	wire st_dec1  = (state_ff == S_DEC1);
	wire st_enc_b = (state_ff == S_ENC_B);
	wire in_cipher = st_enc_a | st_dec0 | st_dec1 | st_enc_b;
	// a done is only believed after our own start went out
	wire blk_done  = in_cipher & launched_ff & cph_done;
	wire locked    = (fail_cnt_ff > `MAS_FAIL_LIMIT);
	// requests during a cipher step are refused rather than queued
	wire start_ok  = auth_req & ~locked & (st_idle | st_wait);
	wire take_rsp  = rsp_valid & st_wait & ~start_ok;
	wire a_done    = blk_done & st_enc_a;
	wire b0_done   = blk_done & st_dec0;
	wire b1_done   = blk_done & st_dec1;
	wire fin_done  = blk_done & st_enc_b;
	// second cbc block chains on the first ciphertext block
	wire [127:0] echo_nonce = cph_dout ^ rsp_ff[255:128];
	wire echo_match = (echo_nonce == reader_nonce_ff);
	wire verify_ok  = b1_done & echo_match;
	wire verify_bad = b1_done & ~echo_match;

	// ====================================================================
	// cipher engine requests
	assign cph_start   = in_cipher & ~launched_ff;
	assign cph_decrypt = st_dec0 | st_dec1;
	assign cph_key     = root_key;
	assign cph_din     = st_enc_a ? (reader_nonce_ff ^ `MAS_CBC_IV) :
	                     st_enc_b ? (server_nonce_ff ^ `MAS_CBC_IV) :
	                     st_dec0  ? rsp_ff[255:128] :
	                                rsp_ff[127:0];

	// ====================================================================
	// sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (start_ok) begin
					nxt_state = S_ENC_A;
				end
			end
			S_ENC_A: begin
				if (a_done) begin
					nxt_state = S_WAIT_RSP;
				end
			end
			S_WAIT_RSP: begin
				if (start_ok) begin
					nxt_state = S_ENC_A;
				end else if (take_rsp) begin
					nxt_state = S_DEC0;
				end
			end
			S_DEC0: begin
				if (b0_done) begin
					nxt_state = S_DEC1;
				end
			end
			S_DEC1: begin
				if (verify_ok) begin
					nxt_state = S_ENC_B;
				end else if (verify_bad) begin
					nxt_state = S_IDLE;
				end
			end
			S_ENC_B: begin
				if (fin_done) begin
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff    <= S_IDLE;
			launched_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			launched_ff <= in_cipher & ~blk_done;
		end
	end

	// ====================================================================
	// nonces and response
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reader_nonce_ff <= `MAS_NONCE_CLEAR;
		end else if (start_ok) begin
			reader_nonce_ff <= fresh_nonce;
		end else if (verify_bad) begin
			reader_nonce_ff <= `MAS_NONCE_CLEAR;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			server_nonce_ff <= `MAS_NONCE_CLEAR;
		end else if (start_ok | verify_bad) begin
			server_nonce_ff <= `MAS_NONCE_CLEAR;
		end else if (b0_done) begin
			server_nonce_ff <= cph_dout ^ `MAS_CBC_IV;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_ff <= `MAS_RSP_CLEAR;
		end else if (start_ok | verify_bad) begin
			rsp_ff <= `MAS_RSP_CLEAR;
		end else if (take_rsp) begin
			rsp_ff <= rsp_data;
		end
	end

	// ====================================================================
	// failure count and lockout, only reset_n lifts the lockout
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fail_cnt_ff <= `MAS_FAIL_ZERO;
		end else if (fin_done) begin
			fail_cnt_ff <= `MAS_FAIL_ZERO;
		end else if (verify_bad && fail_cnt_ff != `MAS_FAIL_MAX) begin
			fail_cnt_ff <= fail_cnt_ff + `MAS_FAIL_ONE;
		end
	end

	// ====================================================================
	// session key and answers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			session_key_ff   <= `MAS_NONCE_CLEAR;
			session_valid_ff <= 1'b0;
		end else if (start_ok) begin
			session_key_ff   <= `MAS_NONCE_CLEAR;
			session_valid_ff <= 1'b0;
		end else if (fin_done) begin
			session_key_ff   <= {server_nonce_ff[127:64], reader_nonce_ff[127:64]};
			session_valid_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ans_data_ff <= `MAS_NONCE_CLEAR;
		end else if (a_done | fin_done) begin
			ans_data_ff <= cph_dout;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ans_valid_ff   <= 1'b0;
			ans_final_ff   <= 1'b0;
			auth_fail_ff   <= 1'b0;
			req_refused_ff <= 1'b0;
		end else begin
			ans_valid_ff   <= a_done | fin_done;
			ans_final_ff   <= fin_done;
			auth_fail_ff   <= verify_bad;
			req_refused_ff <= auth_req & ~start_ok;
		end
	end

	// ====================================================================
	// outputs
	assign ans_valid     = ans_valid_ff;
	assign ans_data      = ans_data_ff;
	assign ans_final     = ans_final_ff;
	assign auth_fail     = auth_fail_ff;
	assign req_refused   = req_refused_ff;
	assign locked_out    = locked;
	assign busy          = ~st_idle;
	assign session_key   = session_key_ff;
	assign session_valid = session_valid_ff;
	assign secure_wr_ok  = secure_wr_req & session_valid_ff;

endmodule

// ==== testbench/mas_auth_core_properties.sv ====
// Purpose: port properties of mas_auth_core
// Assumes: one clock, reset_n async active low
// Notes:   sees top ports only
module mas_auth_core_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic auth_req,
	input wire logic busy,
	input wire logic locked_out,
	input wire logic req_refused,
	input wire logic auth_fail,
	input wire logic ans_valid,
	input wire logic ans_final,
	input wire logic session_valid,
	input wire logic secure_wr_req,
	input wire logic secure_wr_ok,
	input wire logic cph_start,
	input wire logic cph_decrypt,
	input wire logic cph_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ==========
	// properties
	property p_wr_gate;
		secure_wr_ok == (secure_wr_req && session_valid);
	endproperty
	a_wr_gate: assert property (p_wr_gate) else $error("secure write gate wrong");
	property p_take;
		auth_req && !busy && !locked_out |=> cph_start && !cph_decrypt && !session_valid;
	endproperty
	a_take: assert property (p_take) else $error("request not started");
	property p_ans_src;
		ans_valid |-> $past(cph_done);
	endproperty
	a_ans_src: assert property (p_ans_src) else $error("answer without cipher result");
	property p_abort;
		auth_fail |-> !busy && !session_valid && !ans_valid;
	endproperty
	a_abort: assert property (p_abort) else $error("mismatch did not abort");
	property p_lock;
		locked_out && auth_req |=> req_refused && !cph_start;
	endproperty
	a_lock: assert property (p_lock) else $error("locked request accepted");
	property p_hold;
		cph_start |=> $stable(cph_decrypt) && !cph_start;
	endproperty
	a_hold: assert property (p_hold) else $error("cipher step not held");
	property p_sess;
		$rose(session_valid) |-> ans_valid && ans_final;
	endproperty
	a_sess: assert property (p_sess) else $error("session without final answer");
	property p_final;
		ans_valid && ans_final |-> session_valid && !busy;
	endproperty
	a_final: assert property (p_final) else $error("final answer without session");
	c_final: cover property (ans_valid && ans_final);
	c_fail: cover property (auth_fail);
	c_lock: cover property (locked_out && auth_req);
endmodule

bind mas_auth_core mas_auth_core_props u_props (
	.clk(clk), .reset_n(reset_n), .auth_req(auth_req), .busy(busy),
	.locked_out(locked_out), .req_refused(req_refused), .auth_fail(auth_fail),
	.ans_valid(ans_valid), .ans_final(ans_final), .session_valid(session_valid),
	.secure_wr_req(secure_wr_req), .secure_wr_ok(secure_wr_ok),
	.cph_start(cph_start), .cph_decrypt(cph_decrypt), .cph_done(cph_done)
);

// ==== testbench/mas_cph_model.sv ====
// Purpose: block cipher engine stand-in
// Assumes: one block at a time
// Notes:   lat sets extra wait cycles before done
module mas_cph_model import mas_pkg::*; (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [3:0] lat,
	input  wire logic       cph_start,
	input  wire logic       cph_decrypt,
	input  mas_blk_t        cph_key,
	input  mas_blk_t        cph_din,
	output logic            cph_done,
	output mas_blk_t        cph_dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_ff;
	logic       run_ff;
	logic       fin;
	mas_blk_t   x;
	mas_blk_t   y;
	// invertible rotate and key mix, so the server side can mirror it
	assign x   = cph_din ^ cph_key;
	assign y   = cph_decrypt ? {x[0], x[127:1]} : {cph_din[126:0], cph_din[127]} ^ cph_key;
	assign fin = cph_start ? (lat == 4'h0) : (run_ff && cnt_ff == 4'h0);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_ff   <= 1'h0;
			cnt_ff   <= 4'h0;
			cph_done <= 1'h0;
			cph_dout <= '0;
		end else begin
			run_ff   <= cph_start ? (lat != 4'h0) : (run_ff && !fin);
			cnt_ff   <= cph_start ? lat - 4'h1 : cnt_ff - 4'h1;
			cph_done <= fin;
			// toggling between answers so a stale result never looks valid
			cph_dout <= fin ? y : ~cph_dout;
		end
	end
endmodule

// ==== testbench/mas_auth_core_tb.sv ====
// Purpose: self-checking bench of mas_auth_core
// Assumes: bench plays the server side
// Notes:   inputs change on falling edges
module mas_auth_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mas_pkg::*;
	localparam mas_blk_t KEY = 128'hC3A55A3C0F0FF0F0123456789ABCDEF0;
	logic         clk;
	logic         reset_n;
	logic         entropy_in = 1'h0;
	logic         auth_req, rsp_valid, secure_wr_req;
	logic [255:0] rsp_data;
	logic [3:0]   lat;
	logic         ans_valid, ans_final, req_refused, auth_fail, locked_out, busy;
	logic         session_valid, secure_wr_ok, cph_start, cph_decrypt, cph_done, f;
	mas_blk_t     ans_data, session_key, cph_key, cph_din, cph_dout, d, rn, rn0;
	int           bad_count, n_checks, cyc;

	mas_auth_core u_dut (
		.clk(clk), .reset_n(reset_n), .entropy_in(entropy_in), .root_key(KEY),
		.auth_req(auth_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.ans_valid(ans_valid), .ans_data(ans_data), .ans_final(ans_final),
		.req_refused(req_refused), .auth_fail(auth_fail), .locked_out(locked_out),
		.busy(busy), .session_key(session_key), .session_valid(session_valid),
		.secure_wr_req(secure_wr_req), .secure_wr_ok(secure_wr_ok),
		.cph_start(cph_start), .cph_decrypt(cph_decrypt), .cph_key(cph_key),
		.cph_din(cph_din), .cph_done(cph_done), .cph_dout(cph_dout)
	);
	mas_cph_model u_cph (
		.clk(clk), .reset_n(reset_n), .lat(lat), .cph_start(cph_start),
		.cph_decrypt(cph_decrypt), .cph_key(cph_key), .cph_din(cph_din),
		.cph_done(cph_done), .cph_dout(cph_dout)
	);

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk) entropy_in <= ~entropy_in;
	// ==========
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ==========
	// server side cipher mirror and helpers
	function automatic mas_blk_t enc(mas_blk_t v);
		return {v[126:0], v[127]} ^ KEY;
	endfunction
	function automatic mas_blk_t dec(mas_blk_t v);
		mas_blk_t t;
		t = v ^ KEY;
		return {t[0], t[127:1]};
	endfunction
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic do_reset;
		reset_n = 1'h0;
		repeat (20) @(negedge clk);
		reset_n = 1'h1;
	endtask
	task automatic req;
		auth_req = 1'h1;
		@(negedge clk);
		auth_req = 1'h0;
	endtask
	task automatic wait_out;
		int i;
		for (i = 0; i < 40 && ans_valid !== 1'h1 && auth_fail !== 1'h1; i++) @(negedge clk);
		chk(i < 40, 1'h1);
		d = ans_data;
		f = ans_final;
	endtask
	task automatic send_rsp(input mas_blk_t sn, input mas_blk_t r);
		mas_blk_t c0;
		c0 = enc(sn);
		rsp_data = {c0, enc(r ^ c0)};
		rsp_valid = 1'h1;
		@(negedge clk);
		rsp_valid = 1'h0;
		rsp_data = ~rsp_data;
	endtask

	// ==========
	// scenarios
	task automatic t_good(input mas_blk_t sn, input logic bump);
		req();
		if (bump) begin
			@(negedge clk);
			req();
			chk(req_refused, 1'h1);
		end
		wait_out();
		chk(f, 1'h0);
		chk(secure_wr_ok, 1'h0);
		rn = dec(d);
		send_rsp(sn, rn);
		wait_out();
		chk(f, 1'h1);
		chk(dec(d), sn);
		chk(session_key, {sn[127:64], rn[127:64]});
		chk(secure_wr_ok, 1'h1);
		chk(session_valid, 1'h1);
		secure_wr_req = 1'h0;
		@(negedge clk);
		chk(secure_wr_ok, 1'h0);
		secure_wr_req = 1'h1;
	endtask
	task automatic t_bad;
		req();
		wait_out();
		rn = dec(d);
		send_rsp(rn, rn ^ 128'h1);
		wait_out();
		chk(auth_fail, 1'h1);
		chk(busy, 1'h0);
		@(negedge clk);
	endtask
	task automatic t_restart;
		req();
		wait_out();
		rn0 = dec(d);
		req();
		wait_out();
		rn = dec(d);
		chk(rn !== rn0, 1'h1);
		send_rsp(rn, rn0);
		wait_out();
		chk(auth_fail, 1'h1);
	endtask
	task automatic t_lock;
		int i;
		do_reset();
		for (i = 0; i < 5; i++) t_bad();
		t_good(128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0, 1'h0);
		for (i = 0; i < 6; i++) begin
			chk(locked_out, 1'h0);
			t_bad();
		end
		chk(locked_out, 1'h1);
		req();
		chk(req_refused, 1'h1);
		chk(busy, 1'h0);
		do_reset();
		chk(locked_out, 1'h0);
	endtask

	task automatic tally_and_finish;
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		auth_req = 1'h0;
		rsp_valid = 1'h0;
		rsp_data = '0;
		secure_wr_req = 1'h1;
		lat = 4'h0;
		do_reset();
		t_good(128'hA55A00FF11EE22DD33CC44BB55AA6699, 1'h0);
		lat = 4'h6;
		t_good(128'h00000000000000000000000000000001, 1'h1);
		lat = 4'h0;
		t_restart();
		t_lock();
		tally_and_finish();
	end
endmodule
